// ===== rtl/dsadc_seq.v
`timescale 1ns/100ps
`default_nettype none

`include "dsadc_regs.vh"

module dsadc_seq (
    input  wire I_CLK,
    input  wire I_RESET,
    input  wire I_CE,
    input  wire I_COMPARATOR,
    input  wire I_DISPLAY_UPDATE_IN,
    output reg  O_CHARGE_OFFSET,
    output reg  O_SHORT_INTEGRATOR,
    output reg  O_CONNECT_INPUT,
    output reg  O_INVERT_INPUT,
    output reg  O_CONNECT_REF,
    output reg  O_EOC,
    output reg  O_DIGIT_STROBE_HALF,
    output reg  O_DIGIT_STROBE_B,
    output reg  O_DIGIT_STROBE_C,
    output reg  O_DIGIT_STROBE_D,
    output reg  O_BCD_BIT_ZERO,
    output reg  O_BCD_BIT_ONE,
    output reg  O_BCD_BIT_TWO,
    output reg  O_BCD_BIT_THREE,
    output reg  O_UNDERRANGE_FLAG,
    output reg  O_OVERRANGE_FLAG
);

    // =================================================================
    // Pin synchronisers.
    // =================================================================
    reg        comp_meta_ff;
    reg        comp_ff;
    reg        du_meta_ff;
    reg        du_ff;
    reg        du_prev_ff;

    always @(posedge I_CLK) begin
        if (I_RESET) begin
            comp_meta_ff <= 1'b0;
            comp_ff      <= 1'b0;
            du_meta_ff   <= 1'b0;
            du_ff        <= 1'b0;
            du_prev_ff   <= 1'b0;
        end else if (I_CE) begin
            comp_meta_ff <= I_COMPARATOR;
            comp_ff      <= comp_meta_ff;
            du_meta_ff   <= I_DISPLAY_UPDATE_IN;
            du_ff        <= du_meta_ff;
            du_prev_ff   <= du_ff;
        end
    end

    wire du_rise = du_ff & ~du_prev_ff;

    // =================================================================
    // Conversion sequencer.
    // =================================================================
    reg  [2:0]  seg_ff;
    reg  [2:0]  nxt_seg;
    reg  [12:0] cnt_ff;
    reg  [12:0] offset_ff;
    reg  [12:0] nxt_offset;
    reg         pol_ff;
    reg         nxt_pol;
    reg  [11:0] result_ff;
    reg  [11:0] nxt_result;
    reg         found_ff;
    reg         nxt_found;
    reg         armed_ff;
    reg         nxt_armed;
    reg         eoc_ff;
    reg         seg_done;

    // Reset parks the sequencer outside the six segments, so the first
    // segment after release still gets its full count of charge cycles.
    localparam SEG_IDLE = 3'h7;

    always @* begin
        nxt_seg    = seg_ff;
        nxt_offset = offset_ff;
        nxt_pol    = pol_ff;
        nxt_result = result_ff;
        nxt_found  = found_ff;
        nxt_armed  = armed_ff;
        seg_done   = 1'b0;
        case (seg_ff)
            `DSADC_SEG1: begin
                seg_done = (cnt_ff == `DSADC_AZ_CYCLES - 13'd1);
                if (seg_done) begin
                    nxt_seg = `DSADC_SEG2;
                end
            end
            `DSADC_SEG2: begin
                // A comparator that never trips still ends the segment in time.
                seg_done = ~comp_ff | (cnt_ff == `DSADC_OFFSET_MAX);
                if (seg_done) begin
                    nxt_offset = cnt_ff + 13'd1;
                    nxt_seg    = `DSADC_SEG3;
                end
            end
            `DSADC_SEG3: begin
                seg_done = (cnt_ff == `DSADC_AZ_CYCLES - 13'd1);
                if (seg_done) begin
                    nxt_seg = `DSADC_SEG4;
                end
            end
            `DSADC_SEG4: begin
                seg_done = (cnt_ff == `DSADC_INTEGRATE_CYCLES - 13'd1);
                if (seg_done) begin
                    // A low comparator means the ramp went the wrong way.
                    nxt_pol = pol_ff ^ ~comp_ff;
                    nxt_seg = `DSADC_SEG5;
                end
            end
            `DSADC_SEG5: begin
                seg_done = (cnt_ff + 13'd1 >= offset_ff);
                if (seg_done) begin
                    nxt_found  = 1'b0;
                    nxt_result = `DSADC_FULL_SCALE + 12'd1;
                    nxt_seg    = `DSADC_SEG6;
                end
            end
            `DSADC_SEG6: begin
                if (~comp_ff & ~found_ff) begin
                    nxt_found  = 1'b1;
                    nxt_result = cnt_ff[12:1];
                end
                seg_done = (cnt_ff == `DSADC_DEINT_CYCLES - 13'd1);
                if (seg_done) begin
                    nxt_seg = `DSADC_SEG1;
                end
            end
            default: begin
                seg_done = 1'b1;
                nxt_seg  = `DSADC_SEG1;
            end
        endcase
        // The update request must come before the ramp-down starts.
        if (du_rise & (seg_ff < `DSADC_SEG5)) begin
            nxt_armed = 1'b1;
        end else if (eoc_ff) begin
            // Cleared one cycle after the end so the armed load still sees it.
            nxt_armed = 1'b0;
        end
    end

    always @(posedge I_CLK) begin
        if (I_RESET) begin
            seg_ff    <= SEG_IDLE;
            cnt_ff    <= 13'h0000;
            offset_ff <= 13'h0000;
            pol_ff    <= 1'b1;
            result_ff <= 12'h000;
            found_ff  <= 1'b0;
            armed_ff  <= 1'b0;
            eoc_ff    <= 1'b0;
        end else if (I_CE) begin
            seg_ff    <= nxt_seg;
            cnt_ff    <= seg_done ? 13'h0000 : cnt_ff + 13'h0001;
            offset_ff <= nxt_offset;
            pol_ff    <= nxt_pol;
            result_ff <= nxt_result;
            found_ff  <= nxt_found;
            armed_ff  <= nxt_armed;
            eoc_ff    <= (seg_ff == `DSADC_SEG6) & seg_done;
        end
    end

    // =================================================================
    // Analog switch controls.
    // =================================================================
    always @(posedge I_CLK) begin
        if (I_RESET) begin
            O_CHARGE_OFFSET    <= 1'b0;
            O_SHORT_INTEGRATOR <= 1'b0;
            O_CONNECT_INPUT    <= 1'b0;
            O_INVERT_INPUT     <= 1'b0;
            O_CONNECT_REF      <= 1'b0;
            O_EOC              <= 1'b0;
        end else if (I_CE) begin
            O_CHARGE_OFFSET    <= (nxt_seg == `DSADC_SEG1) | (nxt_seg == `DSADC_SEG3);
            O_SHORT_INTEGRATOR <= (nxt_seg == `DSADC_SEG1) | (nxt_seg == `DSADC_SEG3);
            O_CONNECT_INPUT    <= (nxt_seg == `DSADC_SEG4);
            O_INVERT_INPUT     <= ~nxt_pol;
            O_CONNECT_REF      <= (nxt_seg == `DSADC_SEG5) | (nxt_seg == `DSADC_SEG6);
            O_EOC              <= (seg_ff == `DSADC_SEG6) & seg_done;
        end
    end

    // =================================================================
    // Output latches, loaded at the end of an armed conversion.
    // =================================================================
    function [15:0] to_bcd;
        input [10:0] v;
        reg   [26:0] sh;
        integer      i;
        begin
            sh = {16'h0000, v};
            for (i = 0; i < 11; i = i + 1) begin
                if (sh[14:11] > 4'h4) sh[14:11] = sh[14:11] + 4'h3;
                if (sh[18:15] > 4'h4) sh[18:15] = sh[18:15] + 4'h3;
                if (sh[22:19] > 4'h4) sh[22:19] = sh[22:19] + 4'h3;
                if (sh[26:23] > 4'h4) sh[26:23] = sh[26:23] + 4'h3;
                sh = {sh[25:0], 1'b0};
            end
            to_bcd = sh[26:11];
        end
    endfunction

    wire        over     = (result_ff > `DSADC_FULL_SCALE);
    wire        under    = (result_ff < `DSADC_UNDERRANGE_LIM);
    wire [11:0] clipped  = over ? `DSADC_FULL_SCALE : result_ff;
    wire [15:0] bcd_now  = to_bcd(clipped[10:0]);

    reg  [3:0]  dig_b_ff;
    reg  [3:0]  dig_c_ff;
    reg  [3:0]  dig_d_ff;
    reg  [3:0]  half_ff;
    reg  [3:0]  nxt_half;

    always @* begin
        nxt_half = 4'h0;
        nxt_half[`DSADC_HD_NOTONE_BIT]   = ~(clipped >= `DSADC_THOUSAND);
        nxt_half[`DSADC_HD_POSITIVE_BIT] = pol_ff;
        nxt_half[`DSADC_HD_OUTRANGE_BIT] = over | under;
        nxt_half[`DSADC_HD_NOTFULL_BIT]  = ~(clipped >= `DSADC_THOUSAND) | over | under;
    end

    always @(posedge I_CLK) begin
        if (I_RESET) begin
            dig_b_ff          <= 4'h0;
            dig_c_ff          <= 4'h0;
            dig_d_ff          <= 4'h0;
            half_ff           <= 4'he;
            O_UNDERRANGE_FLAG <= 1'b0;
            O_OVERRANGE_FLAG  <= 1'b0;
        end else if (I_CE & eoc_ff & armed_ff) begin
            dig_b_ff          <= bcd_now[11:8];
            dig_c_ff          <= bcd_now[7:4];
            dig_d_ff          <= bcd_now[3:0];
            half_ff           <= nxt_half;
            O_UNDERRANGE_FLAG <= under;
            O_OVERRANGE_FLAG  <= over;
        end
    end

    // =================================================================
    // Digit multiplexer.
    // =================================================================
    wire [1:0] slot;
    wire [4:0] pos;

    dsadc_scan u_scan (
        .i_clk     (I_CLK),
        .i_reset   (I_RESET),
        .i_ce      (I_CE),
        .i_restart (eoc_ff),
        .o_slot    (slot),
        .o_pos     (pos)
    );

    // Each slot opens with blanking so the data lines settle before a strobe.
    wire       show = (pos >= `DSADC_BLANK_CYCLES);
    reg  [3:0] nxt_strobe;
    reg  [3:0] nxt_bcd;

    always @* begin
        nxt_strobe = 4'h0;
        nxt_bcd    = half_ff;
        case (slot)
            2'h0: begin
                nxt_bcd    = half_ff;
                nxt_strobe = {3'h0, show};
            end
            2'h1: begin
                nxt_bcd    = dig_b_ff;
                nxt_strobe = {2'h0, show, 1'b0};
            end
            2'h2: begin
                nxt_bcd    = dig_c_ff;
                nxt_strobe = {1'b0, show, 2'h0};
            end
            2'h3: begin
                nxt_bcd    = dig_d_ff;
                nxt_strobe = {show, 3'h0};
            end
            default: begin
                nxt_bcd    = half_ff;
                nxt_strobe = 4'h0;
            end
        endcase
    end

    always @(posedge I_CLK) begin
        if (I_RESET) begin
            O_DIGIT_STROBE_HALF <= 1'b0;
            O_DIGIT_STROBE_B    <= 1'b0;
            O_DIGIT_STROBE_C    <= 1'b0;
            O_DIGIT_STROBE_D    <= 1'b0;
            O_BCD_BIT_ZERO      <= 1'b0;
            O_BCD_BIT_ONE       <= 1'b0;
            O_BCD_BIT_TWO       <= 1'b0;
            O_BCD_BIT_THREE     <= 1'b0;
        end else if (I_CE) begin
            O_DIGIT_STROBE_HALF <= nxt_strobe[0];
            O_DIGIT_STROBE_B    <= nxt_strobe[1];
            O_DIGIT_STROBE_C    <= nxt_strobe[2];
            O_DIGIT_STROBE_D    <= nxt_strobe[3];
            O_BCD_BIT_ZERO      <= nxt_bcd[0];
            O_BCD_BIT_ONE       <= nxt_bcd[1];
            O_BCD_BIT_TWO       <= nxt_bcd[2];
            O_BCD_BIT_THREE     <= nxt_bcd[3];
        end
    end

endmodule

`default_nettype wire

// ===== rtl/dsadc_regs.vh
`ifndef DSADC_REGS_VH
`define DSADC_REGS_VH

// =====================================================================
// Conversion segment lengths, in system clock periods.
// =====================================================================
`define DSADC_AZ_CYCLES        13'd4000
`define DSADC_OFFSET_MAX       13'd798
`define DSADC_INTEGRATE_CYCLES 13'd4000
`define DSADC_DEINT_CYCLES     13'd4000

// =====================================================================
// Result scaling and range limits.
// =====================================================================
`define DSADC_FULL_SCALE       12'd1999
`define DSADC_UNDERRANGE_LIM   12'd180
`define DSADC_THOUSAND         12'd1000

// =====================================================================
// Digit scan timing: four slots make up one multiplex period of 80 clocks.
// =====================================================================
`define DSADC_SCAN_PERIOD      7'd80
`define DSADC_SLOT_CYCLES      5'd20
`define DSADC_BLANK_CYCLES     5'd2

// =====================================================================
// Sequencer states.
// =====================================================================
`define DSADC_SEG1             3'h0
`define DSADC_SEG2             3'h1
`define DSADC_SEG3             3'h2
`define DSADC_SEG4             3'h3
`define DSADC_SEG5             3'h4
`define DSADC_SEG6             3'h5

// =====================================================================
// Half-digit slot bit positions.
// =====================================================================
`define DSADC_HD_OUTRANGE_BIT  0
`define DSADC_HD_NOTFULL_BIT   1
`define DSADC_HD_POSITIVE_BIT  2
`define DSADC_HD_NOTONE_BIT    3

`endif

// ===== rtl/dsadc_scan.v
`timescale 1ns/100ps
`default_nettype none

`include "dsadc_regs.vh"

module dsadc_scan (
    input  wire       i_clk,
    input  wire       i_reset,
    input  wire       i_ce,
    input  wire       i_restart,
    output reg  [1:0] o_slot,
    output reg  [4:0] o_pos
);

    // =================================================================
    // Slot and position counters, 4 slots of 20 clocks each.
    // =================================================================
    always @(posedge i_clk) begin
        if (i_reset) begin
            o_slot <= 2'h0;
            o_pos  <= 5'h00;
        end else if (i_ce) begin
            if (i_restart) begin
                o_slot <= 2'h0;
                o_pos  <= 5'h00;
            end else if (o_pos == `DSADC_SLOT_CYCLES - 5'd1) begin
                o_slot <= o_slot + 2'h1;
                o_pos  <= 5'h00;
            end else begin
                o_pos <= o_pos + 5'h01;
            end
        end
    end

endmodule

`default_nettype wire

// ===== tb/dsadc_seq_monitor.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Scan and sequencer checks.
// ==========
module dsadc_seq_monitor (
    input wire logic I_CLK,
    input wire logic I_RESET,
    input wire logic O_CHARGE_OFFSET,
    input wire logic O_CONNECT_REF,
    input wire logic O_EOC,
    input wire logic O_DIGIT_STROBE_HALF,
    input wire logic O_DIGIT_STROBE_B,
    input wire logic O_DIGIT_STROBE_C,
    input wire logic O_DIGIT_STROBE_D,
    input wire logic O_BCD_BIT_ZERO,
    input wire logic O_BCD_BIT_ONE,
    input wire logic O_BCD_BIT_TWO,
    input wire logic O_BCD_BIT_THREE,
    input wire logic O_UNDERRANGE_FLAG,
    input wire logic O_OVERRANGE_FLAG
);
    wire  [3:0]  stb = {O_DIGIT_STROBE_HALF, O_DIGIT_STROBE_B,
                        O_DIGIT_STROBE_C, O_DIGIT_STROBE_D};
    wire  [3:0]  nib = {O_BCD_BIT_THREE, O_BCD_BIT_TWO, O_BCD_BIT_ONE, O_BCD_BIT_ZERO};
    logic [12:0] run_ff;
    logic [12:0] chg_ff;

    // Run lengths still hold the finished count on the first sample after the fall.
    always_ff @(posedge I_CLK) begin
        if (I_RESET || stb == 4'h0) begin
            run_ff <= 13'h0000;
        end else begin
            run_ff <= run_ff + 13'h0001;
        end
    end

    always_ff @(posedge I_CLK) begin
        if (I_RESET || !O_CHARGE_OFFSET) begin
            chg_ff <= 13'h0000;
        end else begin
            chg_ff <= chg_ff + 13'h0001;
        end
    end

    default clocking cb @(posedge I_CLK);
    endclocking
    default disable iff (I_RESET);

    AST_ONE_STROBE: assert property ($onehot0(stb))
        else $error("more than one digit strobe high");
    AST_EOC_SHORT: assert property (O_EOC |=> !O_EOC)
        else $error("end of conversion pulse too long");
    AST_HALF_FIRST: assert property (O_EOC |=> ##1 (stb == 4'h0)[*2] ##1 (stb == 4'h8))
        else $error("half digit strobe not first after end of conversion");
    AST_WIDTH: assert property ($fell(|stb) && !$past(O_EOC) && !$past(O_EOC, 2) |-> run_ff == 13'h0012)
        else $error("digit strobe width wrong");
    AST_GAP: assert property ($fell(|stb) && !$past(O_EOC) |-> (stb == 4'h0)[*2]
        ##1 (stb != 4'h0 || O_EOC || $past(O_EOC) || $past(O_EOC, 2)))
        else $error("blanking gap not two cycles");
    AST_ORDER_B: assert property ($rose(stb[2]) |-> $past(stb[3], 3))
        else $error("second strobe not after half strobe");
    AST_ORDER_D: assert property ($rose(stb[0]) |-> $past(stb[1], 3))
        else $error("last strobe not after third strobe");
    AST_STABLE: assert property (|stb && $past(|stb) |-> $stable(nib))
        else $error("nibble moved under a strobe");
    AST_HALF_CODE: assert property (stb[3] |-> nib[1] == (nib[3] | nib[0]))
        else $error("half digit nibble coding wrong");
    AST_OR_CODE: assert property (stb[3] && O_OVERRANGE_FLAG && !$past(O_EOC) |-> !nib[3] && nib[0])
        else $error("overrange not coded in half slot");
    AST_FLAGS: assert property (!(O_UNDERRANGE_FLAG && O_OVERRANGE_FLAG))
        else $error("both range flags high");
    AST_SEG1: assert property ($fell(O_CHARGE_OFFSET) |-> chg_ff == 13'h0fa0)
        else $error("auto zero segment length wrong");
    AST_EOC_END: assert property ($fell(O_CONNECT_REF) |-> O_EOC)
        else $error("ramp down ended without end of conversion");
endmodule

bind dsadc_seq dsadc_seq_monitor u_mon (
    .I_CLK(I_CLK),
    .I_RESET(I_RESET),
    .O_CHARGE_OFFSET(O_CHARGE_OFFSET),
    .O_CONNECT_REF(O_CONNECT_REF),
    .O_EOC(O_EOC),
    .O_DIGIT_STROBE_HALF(O_DIGIT_STROBE_HALF),
    .O_DIGIT_STROBE_B(O_DIGIT_STROBE_B),
    .O_DIGIT_STROBE_C(O_DIGIT_STROBE_C),
    .O_DIGIT_STROBE_D(O_DIGIT_STROBE_D),
    .O_BCD_BIT_ZERO(O_BCD_BIT_ZERO),
    .O_BCD_BIT_ONE(O_BCD_BIT_ONE),
    .O_BCD_BIT_TWO(O_BCD_BIT_TWO),
    .O_BCD_BIT_THREE(O_BCD_BIT_THREE),
    .O_UNDERRANGE_FLAG(O_UNDERRANGE_FLAG),
    .O_OVERRANGE_FLAG(O_OVERRANGE_FLAG)
);
`default_nettype wire

// ===== tb/dsadc_disp_model.sv
`timescale 1ns/100ps
`default_nettype none
// ==========
// Display reader: keeps the last nibble seen under each digit strobe.
// ==========
module dsadc_disp_model (
    input  wire logic       i_clk,
    input  wire logic [3:0] i_strobe,
    input  wire logic [3:0] i_bcd,
    output logic      [3:0] o_half,
    output logic      [3:0] o_b,
    output logic      [3:0] o_c,
    output logic      [3:0] o_d
);
    always_ff @(posedge i_clk) begin
        if (i_strobe[3]) begin
            o_half <= i_bcd;
        end
        if (i_strobe[2]) begin
            o_b <= i_bcd;
        end
        if (i_strobe[1]) begin
            o_c <= i_bcd;
        end
        if (i_strobe[0]) begin
            o_d <= i_bcd;
        end
    end
endmodule
`default_nettype wire

// ===== tb/dual_slope_adc_sequencer_mux_tb_top.sv
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin n_mismatch++; \
    $display("[ERR] %s exp %0h got %0h", nm, e, g); end end
module dual_slope_adc_sequencer_mux_tb_top;
    logic      clk;
    logic      rst;
    logic      cmp;
    logic      du;
    wire       chg, shr, cin, inv, cref, eoc, sh, sb, sc, sd, q0, q1, q2, q3, ur, ovr;
    wire [3:0] hd, db, dc, dd;
    integer    seed = 19781;
    integer    n_mismatch = 0;
    integer    tests_run = 0;
    integer    cyc = 0;
    integer    n;
    integer    r;

    dsadc_seq dut (
        .I_CLK(clk), .I_RESET(rst), .I_CE(1'b1), .I_COMPARATOR(cmp),
        .I_DISPLAY_UPDATE_IN(du), .O_CHARGE_OFFSET(chg), .O_SHORT_INTEGRATOR(shr),
        .O_CONNECT_INPUT(cin), .O_INVERT_INPUT(inv), .O_CONNECT_REF(cref), .O_EOC(eoc),
        .O_DIGIT_STROBE_HALF(sh), .O_DIGIT_STROBE_B(sb), .O_DIGIT_STROBE_C(sc),
        .O_DIGIT_STROBE_D(sd), .O_BCD_BIT_ZERO(q0), .O_BCD_BIT_ONE(q1),
        .O_BCD_BIT_TWO(q2), .O_BCD_BIT_THREE(q3), .O_UNDERRANGE_FLAG(ur),
        .O_OVERRANGE_FLAG(ovr)
    );

    dsadc_disp_model u_disp (
        .i_clk(clk), .i_strobe({sh, sb, sc, sd}), .i_bcd({q3, q2, q1, q0}),
        .o_half(hd), .o_b(db), .o_c(dc), .o_d(dd)
    );

    initial begin
        clk = 1'b0;
        forever #2.5 clk = ~clk;
    end

    // ==========
    // Closing and hang guard; four conversions need about 68000 cycles.
    // ==========
    task end_sim;
        $display("checks %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk) begin
        cyc = cyc + 1;
        if (cyc == 80000) begin
            n_mismatch++;
            $display("[ERR] timeout exp done got hang");
            end_sim;
        end
    end

    // ==========
    // Comparator stand-in: offset length sn, reading sr; sr of 2000 never crosses.
    // ==========
    task automatic conv(input int sn, input int sr, input bit upd, input bit flip);
        while (!chg) @(negedge clk);
        `CHK("short", 1'b1, shr)
        du = upd;
        while (chg) @(negedge clk);
        du = 1'b0;
        repeat (sn) @(negedge clk);
        cmp = 1'b0;
        while (!chg) @(negedge clk);
        while (chg) @(negedge clk);
        cmp = ~flip;
        `CHK("input_on", 1'b1, cin)
        while (!cref) @(negedge clk);
        `CHK("input_off", 1'b0, cin)
        cmp = 1'b1;
        if (sr < 2000) begin
            repeat (sn + 2 * sr) @(negedge clk);
            cmp = 1'b0;
        end
        while (!eoc) @(negedge clk);
        cmp = 1'b1;
        repeat (90) @(negedge clk);
    endtask

    // Sync delays make the count land within a few units, hence the window of three.
    task automatic check(input int er);
        int got;
        int lim;
        got = (hd[3] ? 0 : 1000) + 100 * db + 10 * dc + dd;
        lim = (er > 1999) ? 1999 : er;
        `CHK("reading", 1'b1, (got <= lim + 3 && got + 3 >= lim))
        `CHK("decimal", 1'b1, (db < 10 && dc < 10 && dd < 10))
        `CHK("underrange", (er < 180), ur)
        `CHK("overrange", (er > 1999), ovr)
        `CHK("out_of_range", (er < 180 || er > 1999), hd[0])
        $display("test done: reading %0d", er);
    endtask

    initial begin
        rst = 1'b1;
        cmp = 1'b1;
        du = 1'b0;
        repeat (6) @(negedge clk);
        rst = 1'b0;
        n = 10 + $unsigned($random(seed)) % 690;
        conv(n, 100, 1'b1, 1'b0);
        check(100);
        `CHK("positive", 1'b1, hd[2])
        r = 300 + $unsigned($random(seed)) % 1400;
        conv(n, r, 1'b0, 1'b0);
        check(100);
        n = 10 + $unsigned($random(seed)) % 690;
        conv(n, 987, 1'b1, 1'b1);
        check(987);
        `CHK("invert", 1'b1, inv)
        conv(795, 2000, 1'b1, 1'b0);
        check(2000);
        end_sim;
    end
endmodule
`default_nettype wire
